/* svcc_host_model.sv */
`timescale 1ns/10ps
module svcc_host_model
(
    // clock
    input wire logic i_clock,
    // step request
    input wire logic i_go,
    input wire logic [7:0] i_period,
    // step line
    output logic o_step
);
    logic [7:0] cnt_r = 8'h00;

    initial o_step = 1'b0;

    // one-cycle pulse every period clocks, so any period of 2 or more keeps high 1, low period-1
    always @(posedge i_clock)
    begin
        if (!i_go)
            cnt_r <= 8'h00;
        else if (cnt_r == 8'h00)
            cnt_r <= i_period - 8'h01;
        else
            cnt_r <= cnt_r - 8'h01;
        o_step <= #1 i_go && cnt_r == 8'h00;
    end
endmodule : svcc_host_model

/* svcc_pkg.sv */
package svcc_pkg;

    // register indices on the serial register port
    localparam logic [6:0] ADDR_DRIVE_CURRENT = 7'h10;
    localparam logic [6:0] ADDR_POWER_DOWN = 7'h11;
    localparam logic [6:0] ADDR_STEP_INTERVAL = 7'h12;
    localparam logic [6:0] ADDR_QUIET_THRESHOLD = 7'h13;
    localparam logic [6:0] ADDR_VELOCITY_CMD = 7'h22;
    localparam logic [6:0] ADDR_USTEP_POSITION = 7'h6a;
    localparam logic [6:0] ADDR_PHASE_CURRENTS = 7'h6b;

    // drive_current_control field positions
    localparam int HOLD_LSB = 0;
    localparam int RUN_LSB = 8;
    localparam int RAMP_LSB = 16;

    // reset values
    localparam logic [4:0] RUN_CURRENT_RST = 5'h1f;
    localparam logic [7:0] POWER_DOWN_RST = 8'h14;
    localparam logic [19:0] QUIET_THRESHOLD_RST = 20'h00000;
    localparam logic [23:0] VELOCITY_RST = 24'h000000;
    localparam logic [19:0] INTERVAL_MAX = 20'hfffff;

    // nonvolatile code to standstill current / ramp delay
    localparam logic [4:0] HOLD_CODE0 = 5'h10;
    localparam logic [4:0] HOLD_CODE1 = 5'h02;
    localparam logic [4:0] HOLD_CODE2 = 5'h08;
    localparam logic [4:0] HOLD_CODE3 = 5'h18;
    localparam logic [3:0] RAMP_CODE0 = 4'h1;
    localparam logic [3:0] RAMP_CODE1 = 4'h2;
    localparam logic [3:0] RAMP_CODE2 = 4'h4;
    localparam logic [3:0] RAMP_CODE3 = 4'h8;

    // delay unit of power-down and ramp timing, in clocks
    localparam int unsigned DELAY_UNIT_CLOCKS = 262144;
    // phase b offset into the wave table
    localparam logic [9:0] PHASE_B_OFFSET = 10'h100;
    localparam logic [8:0] TABLE_PEAK = 9'h0ff;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [31:0] wdata;
    } svcc_reg_req_t;

    typedef enum logic [1:0] {
        SVCC_RUN = 2'b00,
        SVCC_WAIT = 2'b01,
        SVCC_RAMP = 2'b10,
        SVCC_HOLD = 2'b11
    } svcc_pwr_state_t;

endpackage : svcc_pkg

/* svcc_top.sv */
// Behaviour
// - standstill current code n is (n+1)/32
// - zero hold in quiet mode: freewheel or brake
// - run current same coding, resets to 31
// - ramp delay 0 instant, else n*2^18 per step
// - power-down delay in 2^18 clocks, resets 20
// - measure 20-bit clocks between microsteps
// - saturate interval on overflow or standstill
// - hysteresis lower compare is thr*15/16-1
// - quiet mode while interval >= threshold
// - nonzero velocity generates steps, sign direction
// - sequencer registers read-only, writes ignored
// - 10-bit position, phase b offset 256
// - signed currents at bits 8:0 and 24:16
// - reduction only when reduction enabled
// - reset hold current from 2-bit code
`timescale 1ns/10ps
module svcc_top
#(
    parameter int unsigned TICK_CYCLES = svcc_pkg::DELAY_UNIT_CLOCKS,
    parameter logic [19:0] INTERVAL_LIMIT = svcc_pkg::INTERVAL_MAX
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // register port from the serial interface
    input wire svcc_pkg::svcc_reg_req_t i_req,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // step interface and straps
    input wire logic i_step,
    input wire logic i_dir,
    input wire logic i_reduction_en,
    input wire logic i_quiet_cfg,
    input wire logic i_brake_sel,
    input wire logic [1:0] i_otp_hold_code,
    input wire logic [1:0] i_otp_ramp_code,
    // driver control
    output logic [4:0] o_current_scale,
    output logic o_quiet_mode,
    output logic o_freewheel,
    output logic o_brake,
    output logic o_standstill,
    output logic o_step_monitor,
    output logic o_dir_active
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    logic [4:0] standstill_current_r;
    logic [4:0] run_current_r;
    logic [3:0] current_ramp_delay_r;
    logic [7:0] power_down_delay_r;
    logic [19:0] quiet_mode_threshold_r;
    logic [23:0] internal_velocity_command_r;
    logic otp_loaded_r;
    logic step_in_r;
    logic [23:0] vel_acc_r;
    logic [19:0] interval_cnt_r;
    logic [19:0] step_interval_measure_r;
    logic [9:0] microstep_position_r;
    logic [TW-1:0] tick_cnt_r;
    logic tick;
    logic [7:0] pd_cnt_r;
    logic [3:0] ramp_cnt_r;
    svcc_pkg::svcc_pwr_state_t pwr_r;
    logic [8:0] phase_a_table_current;
    logic [8:0] phase_b_table_current;
    logic [23:0] vel_mag;
    logic [24:0] vel_sum;
    logic gen_step;
    logic ustep;
    logic move_dir;
    logic [23:0] thr_prod;
    logic [19:0] thr_low;
    logic wr_drive;

    function automatic logic [4:0] hold_from_code(input logic [1:0] code);
        unique case (code)
            2'b00: hold_from_code = svcc_pkg::HOLD_CODE0;
            2'b01: hold_from_code = svcc_pkg::HOLD_CODE1;
            2'b10: hold_from_code = svcc_pkg::HOLD_CODE2;
            2'b11: hold_from_code = svcc_pkg::HOLD_CODE3;
        endcase
    endfunction : hold_from_code

    function automatic logic [3:0] ramp_from_code(input logic [1:0] code);
        unique case (code)
            2'b00: ramp_from_code = svcc_pkg::RAMP_CODE0;
            2'b01: ramp_from_code = svcc_pkg::RAMP_CODE1;
            2'b10: ramp_from_code = svcc_pkg::RAMP_CODE2;
            2'b11: ramp_from_code = svcc_pkg::RAMP_CODE3;
        endcase
    endfunction : ramp_from_code

    assign wr_drive = i_req.wr && (i_req.addr == svcc_pkg::ADDR_DRIVE_CURRENT);

    // register writes; sequencer and interval addresses have no write target
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            run_current_r <= svcc_pkg::RUN_CURRENT_RST;
            power_down_delay_r <= svcc_pkg::POWER_DOWN_RST;
            quiet_mode_threshold_r <= svcc_pkg::QUIET_THRESHOLD_RST;
            internal_velocity_command_r <= svcc_pkg::VELOCITY_RST;
        end
        else if (i_req.wr)
        begin
            unique case (i_req.addr)
                svcc_pkg::ADDR_DRIVE_CURRENT:
                    run_current_r <= i_req.wdata[svcc_pkg::RUN_LSB +: 5];
                svcc_pkg::ADDR_POWER_DOWN:
                    power_down_delay_r <= i_req.wdata[7:0];
                svcc_pkg::ADDR_QUIET_THRESHOLD:
                    quiet_mode_threshold_r <= i_req.wdata[19:0];
                svcc_pkg::ADDR_VELOCITY_CMD:
                    internal_velocity_command_r <= i_req.wdata[23:0];
                default:
                    ;
            endcase
        end
    end

    // hold current and ramp delay come from straps, caught after reset release, until a drive_current_control write replaces them
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            otp_loaded_r <= 1'b0;
            standstill_current_r <= 5'h00;
            current_ramp_delay_r <= 4'h0;
        end
        else if (wr_drive)
        begin
            otp_loaded_r <= 1'b1;
            standstill_current_r <= i_req.wdata[svcc_pkg::HOLD_LSB +: 5];
            current_ramp_delay_r <= i_req.wdata[svcc_pkg::RAMP_LSB +: 4];
        end
        else if (!otp_loaded_r)
        begin
            otp_loaded_r <= 1'b1;
            standstill_current_r <= hold_from_code(i_otp_hold_code);
            current_ramp_delay_r <= ramp_from_code(i_otp_ramp_code);
        end
    end

    // internal pulse generator: accumulator carry is one microstep
    always_comb
    begin
        vel_mag = internal_velocity_command_r[23] ? 24'(-internal_velocity_command_r)
                                                  : internal_velocity_command_r;
        vel_sum = {1'b0, vel_acc_r} + {1'b0, vel_mag};
        gen_step = (internal_velocity_command_r != 24'h000000) && vel_sum[24];
        ustep = (internal_velocity_command_r == 24'h000000) ? (i_step && !step_in_r)
                                                            : gen_step;
        move_dir = (internal_velocity_command_r == 24'h000000) ? i_dir
                                                               : internal_velocity_command_r[23];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            step_in_r <= 1'b0;
            vel_acc_r <= 24'h000000;
            o_step_monitor <= 1'b0;
            o_dir_active <= 1'b0;
        end
        else
        begin
            step_in_r <= i_step;
            vel_acc_r <= (internal_velocity_command_r == 24'h000000) ? 24'h000000 : vel_sum[23:0];
            o_step_monitor <= gen_step;
            o_dir_active <= move_dir;
        end
    end

    // step interval measure; saturating counter doubles as standstill detect
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            interval_cnt_r <= 20'h00000;
            step_interval_measure_r <= svcc_pkg::INTERVAL_MAX;
            o_standstill <= 1'b1;
        end
        else if (ustep)
        begin
            interval_cnt_r <= 20'h00001;
            step_interval_measure_r <= interval_cnt_r;
            o_standstill <= 1'b0;
        end
        else if (interval_cnt_r >= INTERVAL_LIMIT)
        begin
            step_interval_measure_r <= svcc_pkg::INTERVAL_MAX;
            o_standstill <= 1'b1;
        end
        else
        begin
            interval_cnt_r <= interval_cnt_r + 20'h00001;
        end
    end

    // quiet mode switch with hysteresis; zero threshold leaves the configured mode
    always_comb
    begin
        thr_prod = 24'(quiet_mode_threshold_r) * 24'h00000f;
        thr_low = thr_prod[23:4] - 20'h00001;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_quiet_mode <= 1'b0;
        else if (!i_quiet_cfg)
            o_quiet_mode <= 1'b0;
        else if (quiet_mode_threshold_r == 20'h00000)
            o_quiet_mode <= 1'b1;
        else if (o_quiet_mode)
            o_quiet_mode <= (step_interval_measure_r >= thr_low);
        else
            o_quiet_mode <= (step_interval_measure_r >= quiet_mode_threshold_r);
    end

    // delay unit tick; free-running so the first unit may be short by design
    always_ff @(posedge i_clock)
    begin
        if (i_rst || tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + TW'(1);
    end

    assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

    // power-down sequence
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            pwr_r <= svcc_pkg::SVCC_RUN;
            pd_cnt_r <= 8'h00;
            ramp_cnt_r <= 4'h0;
            o_current_scale <= svcc_pkg::RUN_CURRENT_RST;
        end
        else if (!o_standstill || !i_reduction_en)
        begin
            pwr_r <= svcc_pkg::SVCC_RUN;
            pd_cnt_r <= 8'h00;
            o_current_scale <= run_current_r;
        end
        else
        begin
            unique case (pwr_r)
                svcc_pkg::SVCC_RUN:
                begin
                    pwr_r <= svcc_pkg::SVCC_WAIT;
                    pd_cnt_r <= 8'h00;
                    o_current_scale <= run_current_r;
                end
                svcc_pkg::SVCC_WAIT:
                begin
                    o_current_scale <= run_current_r;
                    if (pd_cnt_r >= power_down_delay_r)
                    begin
                        pwr_r <= svcc_pkg::SVCC_RAMP;
                        ramp_cnt_r <= 4'h0;
                    end
                    else if (tick)
                        pd_cnt_r <= pd_cnt_r + 8'h01;
                end
                svcc_pkg::SVCC_RAMP:
                begin
                    if (current_ramp_delay_r == 4'h0 ||
                        o_current_scale <= standstill_current_r)
                    begin
                        o_current_scale <= standstill_current_r;
                        pwr_r <= svcc_pkg::SVCC_HOLD;
                    end
                    else if (tick && ramp_cnt_r + 4'h1 >= current_ramp_delay_r)
                    begin
                        ramp_cnt_r <= 4'h0;
                        o_current_scale <= o_current_scale - 5'h01;
                    end
                    else if (tick)
                        ramp_cnt_r <= ramp_cnt_r + 4'h1;
                end
                svcc_pkg::SVCC_HOLD:
                    o_current_scale <= standstill_current_r;
            endcase
        end
    end

    // zero hold current in quiet mode releases the coils
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_freewheel <= 1'b0;
            o_brake <= 1'b0;
        end
        else
        begin
            o_freewheel <= (pwr_r == svcc_pkg::SVCC_HOLD) && o_standstill && i_reduction_en &&
                           o_quiet_mode && (standstill_current_r == 5'h00) && !i_brake_sel;
            o_brake <= (pwr_r == svcc_pkg::SVCC_HOLD) && o_standstill && i_reduction_en &&
                       o_quiet_mode && (standstill_current_r == 5'h00) && i_brake_sel;
        end
    end

    // microstep sequencer position
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            microstep_position_r <= 10'h000;
        else if (ustep)
            microstep_position_r <= move_dir ? microstep_position_r - 10'h001
                                             : microstep_position_r + 10'h001;
    end

    svcc_wave u_wave_a
    (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pos(microstep_position_r),
        .o_current(phase_a_table_current)
    );

    svcc_wave u_wave_b
    (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pos(microstep_position_r + svcc_pkg::PHASE_B_OFFSET),
        .o_current(phase_b_table_current)
    );

    // read port; write-only registers read as zero
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_reg_rdata <= 32'h00000000;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            o_reg_rvalid <= i_req.rd;
            if (i_req.rd)
            begin
                unique case (i_req.addr)
                    svcc_pkg::ADDR_STEP_INTERVAL:
                        o_reg_rdata <= {12'h000, step_interval_measure_r};
                    svcc_pkg::ADDR_USTEP_POSITION:
                        o_reg_rdata <= {22'h000000, microstep_position_r};
                    svcc_pkg::ADDR_PHASE_CURRENTS:
                        o_reg_rdata <= {7'h00, phase_b_table_current, 7'h00,
                                        phase_a_table_current};
                    default:
                        o_reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule : svcc_top

/* svcc_top_props.sv */
`timescale 1ns/10ps
module svcc_top_props
#(
    parameter int unsigned TICK_CYCLES = 8,
    parameter logic [19:0] INTERVAL_LIMIT = 20'hfffff
)
(
    // clock, reset, register port
    input wire logic i_clock,
    input wire logic i_rst,
    input wire svcc_pkg::svcc_reg_req_t i_req,
    input wire logic [31:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // step, straps, driver control
    input wire logic i_step,
    input wire logic i_reduction_en,
    input wire logic i_quiet_cfg,
    input wire logic [4:0] o_current_scale,
    input wire logic o_quiet_mode,
    input wire logic o_freewheel,
    input wire logic o_brake,
    input wire logic o_standstill,
    input wire logic o_step_monitor,
    input wire logic o_dir_active
);
    logic [4:0] run_r;
    logic [23:0] vel_r;
    logic [19:0] thr_r;

    // shadow of the write-only fields the outputs depend on
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            run_r <= svcc_pkg::RUN_CURRENT_RST;
            vel_r <= svcc_pkg::VELOCITY_RST;
            thr_r <= svcc_pkg::QUIET_THRESHOLD_RST;
        end
        else if (i_req.wr)
        begin
            if (i_req.addr == svcc_pkg::ADDR_DRIVE_CURRENT)
                run_r <= i_req.wdata[12:8];
            if (i_req.addr == svcc_pkg::ADDR_VELOCITY_CMD)
                vel_r <= i_req.wdata[23:0];
            if (i_req.addr == svcc_pkg::ADDR_QUIET_THRESHOLD)
                thr_r <= i_req.wdata[19:0];
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_step_edge;
        (vel_r == 24'h0 && !i_step) ##1 (vel_r == 24'h0 && i_step);
    endsequence

    AST_RUN_WHEN_NOT_REDUCED: assert property (
        (!i_reduction_en && !i_req.wr) |=> o_current_scale == run_r)
        else $error("current scale is not the run current");
    AST_WO_READ_ZERO: assert property (
        (i_req.rd && i_req.addr == svcc_pkg::ADDR_POWER_DOWN) |=> o_reg_rvalid && o_reg_rdata == 32'h0)
        else $error("write-only register read back nonzero");
    AST_INTERVAL_SATURATED: assert property (
        (o_standstill && vel_r == 24'h0 && !i_step && i_req.rd
            && i_req.addr == svcc_pkg::ADDR_STEP_INTERVAL)
        |=> o_reg_rdata == {12'h0, svcc_pkg::INTERVAL_MAX})
        else $error("interval not saturated at standstill");
    AST_STEP_CLEARS_STANDSTILL: assert property (
        s_step_edge |=> !o_standstill)
        else $error("standstill kept after a step");
    AST_QUIET_THR_ZERO: assert property (
        (thr_r == 20'h0 && i_quiet_cfg) [*3] |-> o_quiet_mode)
        else $error("quiet mode off with zero threshold");
    AST_QUIET_NEEDS_CFG: assert property (
        (!i_quiet_cfg) [*3] |-> !o_quiet_mode)
        else $error("quiet mode without configuration");
    AST_COILS_RELEASED: assert property (
        (o_freewheel || o_brake) |-> $past(o_standstill) && $past(o_quiet_mode)
            && o_current_scale == 5'h0 && !(o_freewheel && o_brake))
        else $error("freewheel or brake outside zero hold standstill");
    AST_MONITOR_PULSE: assert property (
        o_step_monitor |=> !o_step_monitor)
        else $error("step monitor longer than one cycle");
    AST_MONITOR_IDLE: assert property (
        (vel_r == 24'h0) [*3] |-> !o_step_monitor)
        else $error("step monitor pulse with zero velocity");
    AST_DIR_FROM_SIGN: assert property (
        (vel_r != 24'h0 && $stable(vel_r)) [*2] |-> o_dir_active == vel_r[23])
        else $error("direction differs from velocity sign");
endmodule : svcc_top_props

bind svcc_top svcc_top_props #(.TICK_CYCLES(TICK_CYCLES), .INTERVAL_LIMIT(INTERVAL_LIMIT))
    i_svcc_top_props (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_step(i_step),
    .i_reduction_en(i_reduction_en), .i_quiet_cfg(i_quiet_cfg),
    .o_current_scale(o_current_scale), .o_quiet_mode(o_quiet_mode),
    .o_freewheel(o_freewheel), .o_brake(o_brake), .o_standstill(o_standstill),
    .o_step_monitor(o_step_monitor), .o_dir_active(o_dir_active));

/* svcc_wave.sv */
`timescale 1ns/10ps
module svcc_wave
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // table position
    input wire logic [9:0] i_pos,
    // signed table current
    output logic [8:0] o_current
);
    // parabolic half wave: x*(512-x)/256, peak clipped to table maximum
    logic [9:0] span;
    logic [18:0] prod;
    logic [8:0] mag;

    always_comb
    begin
        span = 10'h200 - {1'b0, i_pos[8:0]};
        prod = 19'({1'b0, i_pos[8:0]}) * 19'(span);
        mag = (prod[18:8] > 11'(svcc_pkg::TABLE_PEAK)) ? svcc_pkg::TABLE_PEAK : prod[16:8];
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            o_current <= 9'h000;
        else
            o_current <= i_pos[9] ? 9'(-mag) : mag;
    end

endmodule : svcc_wave

/* tb.sv */
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} svcc_note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    svcc_pkg::svcc_reg_req_t req = '0;
    logic go = 1'b0, dir = 1'b0, red = 1'b1, qcfg = 1'b0, bsel = 1'b0;
    logic [7:0] period = 8'h0a, p;
    logic step, rvalid, quiet, fw, brk, stst, smon, dira;
    logic [31:0] rdata;
    logic [4:0] scale, hold;
    logic [3:0] ramp;
    logic [1:0] otp = 2'h0;
    logic [4:0] hcode[4] = '{svcc_pkg::HOLD_CODE0, svcc_pkg::HOLD_CODE1,
        svcc_pkg::HOLD_CODE2, svcc_pkg::HOLD_CODE3};
    int mismatches = 0, check_count = 0, n, cnt;
    int per[5] = '{40, 30, 28, 30, 32};
    logic qexp[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    svcc_note_t notes[$];
    svcc_note_t nt;

    svcc_top #(.TICK_CYCLES(8), .INTERVAL_LIMIT(20'h00040)) i_svcc_top (.i_clock(clock),
        .i_rst(rst), .i_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_step(step),
        .i_dir(dir), .i_reduction_en(red), .i_quiet_cfg(qcfg), .i_brake_sel(bsel),
        .i_otp_hold_code(otp), .i_otp_ramp_code(2'h0), .o_current_scale(scale),
        .o_quiet_mode(quiet), .o_freewheel(fw), .o_brake(brk), .o_standstill(stst),
        .o_step_monitor(smon), .o_dir_active(dira));
    svcc_host_model i_svcc_host_model (.i_clock(clock), .i_go(go), .i_period(period),
        .o_step(step));

    initial forever #25 clock = ~clock;

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        tick(1);
        req.wr = 1'b0;
        tick(1);
    endtask : reg_wr

    task automatic reg_rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({e, m});
        req.rd = 1'b1;
        req.addr = a;
        tick(1);
        req.rd = 1'b0;
        tick(1);
    endtask : reg_rd

    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] m, input logic [31:0] got);
        check_count++;
        if ((got & m) !== (e & m))
        begin
            mismatches++;
            $display("ERROR read data expected %h seen %h", e & m, got & m);
        end
    endtask : cmp_rd

    task automatic cmp_out(input string nm, input logic [7:0] e, input logic [7:0] got);
        check_count++;
        if (got !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask : cmp_out

    task automatic wrap_up;
        // a read that never got its answer leaves a note behind
        if (notes.size() != 0)
        begin
            mismatches++;
            $display("ERROR pending reads expected 0 seen %0d", notes.size());
        end
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // read data is settled by the falling edge
    always @(negedge clock)
    begin
        if (rvalid === 1'b1)
        begin
            if (notes.size() > 0)
                nt = notes.pop_front();
            else
                nt = {32'hdeadbeef, 32'hffffffff};
            cmp_rd(nt.e, nt.m, rdata);
        end
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        mismatches++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(71));
        otp = 2'($urandom % 4);
        tick(12);
        rst = 1'b0;
        // reduction on from reset: 20 ticks wait, then up to 29 ramp steps of 1 tick
        tick(140);
        cmp_out("scale early", 8'd31, 8'(scale));
        tick(360);
        cmp_out("scale otp hold", 8'(hcode[otp]), 8'(scale));
        reg_wr(svcc_pkg::ADDR_USTEP_POSITION, 32'h3ff);
        reg_wr(svcc_pkg::ADDR_STEP_INTERVAL, 32'h1);
        reg_rd(svcc_pkg::ADDR_USTEP_POSITION, 32'h0, 32'h3ff);
        reg_rd(svcc_pkg::ADDR_STEP_INTERVAL, 32'hfffff, '1);
        reg_rd(svcc_pkg::ADDR_POWER_DOWN, 32'h0, '1);
        reg_rd(7'h05, 32'h0, '1);
        p = 8'd4 + 8'($urandom % 30);
        period = p;
        go = 1'b1;
        tick(300 * p);
        go = 1'b0;
        dir = 1'b1;
        tick(2);
        go = 1'b1;
        tick(310 * p);
        go = 1'b0;
        tick(4);
        reg_rd(svcc_pkg::ADDR_STEP_INTERVAL, {24'h0, p}, '1);
        reg_rd(svcc_pkg::ADDR_USTEP_POSITION, 32'd1014, 32'h3ff);
        reg_rd(svcc_pkg::ADDR_PHASE_CURRENTS, 32'h00ff01ed, '1);
        qcfg = 1'b1;
        reg_wr(svcc_pkg::ADDR_QUIET_THRESHOLD, 32'd32);
        go = 1'b1;
        for (n = 0; n < 5; n++)
        begin
            period = 8'(per[n]);
            tick(400);
            cmp_out("quiet", 8'(qexp[n]), 8'(quiet));
        end
        go = 1'b0;
        reg_wr(svcc_pkg::ADDR_QUIET_THRESHOLD, 32'h0);
        reg_wr(svcc_pkg::ADDR_POWER_DOWN, 32'h2);
        period = 8'd8;
        for (n = 0; n < 3; n++)
        begin
            bsel = (n == 2);
            hold = (n == 0) ? 5'd5 : 5'd0;
            ramp = (n == 0) ? 4'd0 : 4'd2;
            reg_wr(svcc_pkg::ADDR_DRIVE_CURRENT, {12'h0, ramp, 3'h0, 5'd9, 3'h0, hold});
            go = 1'b1;
            tick(40);
            cmp_out("scale run", 8'd9, 8'(scale));
            go = 1'b0;
            tick(400);
            cmp_out("scale hold", 8'(hold), 8'(scale));
            cmp_out("freewheel", 8'(hold == 0 && !bsel), 8'(fw));
            cmp_out("brake", 8'(hold == 0 && bsel), 8'(brk));
            red = 1'b0;
            tick(1);
            cmp_out("scale released", 8'd9, 8'(scale));
            red = (n < 2);
        end
        go = 1'b1;
        for (n = 0; n < 2; n++)
        begin
            reg_wr(svcc_pkg::ADDR_VELOCITY_CMD, n ? 32'h400000 : 32'hc00000);
            tick(8);
            cnt = 0;
            repeat (400)
            begin
                tick(1);
                if (smon === 1'b1) cnt++;
            end
            cmp_out("step count", 8'h1, 8'(cnt >= 99 && cnt <= 101));
            cmp_out("direction", 8'(n == 0), 8'(dira));
        end
        reg_wr(svcc_pkg::ADDR_VELOCITY_CMD, 32'h0);
        tick(20);
        wrap_up();
    end
endmodule : tb
